// [timer0_control_and_flags_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module timer0_control_and_flags_bench;
   logic i_clk;
   logic i_rst_b;
   timer0_pkg::reg_req_t i_req;
   timer0_pkg::vector_ack_t i_vector_ack;
   logic i_global_irq_enable;
   logic [2:0] i_clock_source_select;
   logic [2:0] i_waveform_mode_select;
   logic i_ext_count_pin;
   logic i_capture_input_first;
   logic i_capture_input_second;
   logic [7:0] o_rdata;
   logic o_wrap_irq;
   logic o_cmp_a_irq;
   logic o_cmp_b_irq;
   logic o_cmp_a_match;
   logic o_cmp_b_match;
   logic o_prescaler_reset;
   logic o_capture_trigger;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   int psr_cycles = 0;
   int match_a_cnt = 0;
   int match_b_cnt = 0;
   logic [7:0] d;

   timer0_ctrl uut (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_req(i_req),
      .i_vector_ack(i_vector_ack),
      .i_global_irq_enable(i_global_irq_enable),
      .i_clock_source_select(i_clock_source_select),
      .i_waveform_mode_select(i_waveform_mode_select),
      .i_ext_count_pin(i_ext_count_pin),
      .i_capture_input_first(i_capture_input_first),
      .i_capture_input_second(i_capture_input_second),
      .o_rdata(o_rdata),
      .o_wrap_irq(o_wrap_irq),
      .o_cmp_a_irq(o_cmp_a_irq),
      .o_cmp_b_irq(o_cmp_b_irq),
      .o_cmp_a_match(o_cmp_a_match),
      .o_cmp_b_match(o_cmp_b_match),
      .o_prescaler_reset(o_prescaler_reset),
      .o_capture_trigger(o_capture_trigger)
   );

   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   // pulse monitors, so short outputs are never missed by a late sample
   always @(posedge i_clk) begin
      cycles++;
      if (o_prescaler_reset === 1'b1) psr_cycles++;
      if (o_cmp_a_match === 1'b1) match_a_cnt++;
      if (o_cmp_b_match === 1'b1) match_b_cnt++;
      if (cycles == 60000) begin
         errors++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic reg_write(input logic io, input logic [7:0] a, input logic [7:0] wd);
      @(posedge i_clk);
      #5 i_req = '{wr: 1'b1, rd: 1'b0, io_space: io, addr: a, wdata: wd};
      @(posedge i_clk);
      #5 i_req = '0;
   endtask

   // read data is registered at the taking edge and stands one cycle only
   task automatic reg_read(input logic io, input logic [7:0] a, output logic [7:0] q);
      @(posedge i_clk);
      #5 i_req = '{wr: 1'b0, rd: 1'b1, io_space: io, addr: a, wdata: 8'h00};
      @(posedge i_clk);
      #5 i_req = '0;
      q = o_rdata;
   endtask

   task automatic run_cycles(input logic [2:0] cs, input int n);
      i_clock_source_select = cs;
      repeat (n) @(posedge i_clk);
      #5 i_clock_source_select = 3'h0;
   endtask

   task automatic test_reset_values;
      logic [7:0] addrs [6] = '{8'h35, 8'h43, 8'h46, 8'h47, 8'h48, 8'h6E};
      foreach (addrs[k]) begin
         reg_read(1'b0, addrs[k], d);
         check("reset_value", d, 8'h00);
      end
      reg_read(1'b0, 8'h50, d);
      check("unmapped_read", d, 8'h00);
   endtask

   task automatic test_register_access;
      reg_write(1'b0, timer0_pkg::ADDR_CMP_A, 8'hA5);
      reg_read(1'b1, 8'h27, d);
      check("cmp_a_alias", d, 8'hA5);
      reg_write(1'b1, 8'h28, 8'h5A);
      reg_read(1'b0, timer0_pkg::ADDR_CMP_B, d);
      check("cmp_b_alias", d, 8'h5A);
      reg_write(1'b1, 8'h26, 8'h3C);
      reg_read(1'b0, timer0_pkg::ADDR_COUNT, d);
      check("count_load", d, 8'h3C);
      reg_write(1'b0, timer0_pkg::ADDR_IRQ_MASK, 8'hFF);
      reg_read(1'b0, timer0_pkg::ADDR_IRQ_MASK, d);
      check("mask_unused_bits", d, 8'h07);
      // the mask has no alias; io addresses beyond the window decode nothing
      reg_write(1'b1, 8'h66, 8'hFF);
      reg_read(1'b0, timer0_pkg::ADDR_COUNT, d);
      check("io_out_of_window", d, 8'h3C);
      reg_write(1'b0, timer0_pkg::ADDR_IRQ_MASK, 8'h00);
   endtask

   // a window of whole prescaler periods always holds the same tick count
   task automatic test_clock_select;
      int div [6] = '{0, 1, 8, 64, 256, 1024};
      int w;
      logic [7:0] c0;
      for (int k = 0; k < 6; k++) begin
         i_clock_source_select = 3'(k);
         w = (k == 0) ? 40 : 20 * div[k];
         reg_read(1'b0, timer0_pkg::ADDR_COUNT, c0);
         repeat (w - 2) @(posedge i_clk);
         reg_read(1'b0, timer0_pkg::ADDR_COUNT, d);
         check("count_delta", d - c0, (k == 0) ? 8'h00 : 8'h14);
      end
      i_clock_source_select = 3'h0;
   endtask

   task automatic test_ext_pin;
      logic [7:0] c0;
      for (int k = 6; k < 8; k++) begin
         i_clock_source_select = 3'(k);
         reg_read(1'b0, timer0_pkg::ADDR_COUNT, c0);
         repeat (5) begin
            @(posedge i_clk);
            #5 i_ext_count_pin = 1'b1;
            repeat (3) @(posedge i_clk);
            #5 i_ext_count_pin = 1'b0;
            repeat (2) @(posedge i_clk);
         end
         repeat (3) @(posedge i_clk);
         reg_read(1'b0, timer0_pkg::ADDR_COUNT, d);
         check("pin_edge_count", d - c0, 8'h05);
      end
      i_clock_source_select = 3'h0;
   endtask

   task automatic test_flags_irq;
      reg_write(1'b0, timer0_pkg::ADDR_FLAGS, 8'h07);
      reg_write(1'b0, timer0_pkg::ADDR_CMP_A, 8'h20);
      reg_write(1'b0, timer0_pkg::ADDR_CMP_B, 8'h22);
      reg_write(1'b0, timer0_pkg::ADDR_COUNT, 8'h1E);
      reg_write(1'b0, timer0_pkg::ADDR_IRQ_MASK, 8'h07);
      i_global_irq_enable = 1'b1;
      match_a_cnt = 0;
      match_b_cnt = 0;
      run_cycles(3'h1, 12);
      reg_read(1'b1, 8'h15, d);
      check("match_flags", d, 8'h06);
      check("match_pulses", 8'(match_a_cnt + 16 * match_b_cnt), 8'h11);
      check("irq_lines", {5'h00, o_cmp_b_irq, o_cmp_a_irq, o_wrap_irq}, 8'h06);
      reg_write(1'b0, timer0_pkg::ADDR_FLAGS, 8'h02);
      reg_read(1'b0, timer0_pkg::ADDR_FLAGS, d);
      check("w1c_cmp_a", d, 8'h04);
      reg_write(1'b0, timer0_pkg::ADDR_FLAGS, 8'h00);
      reg_read(1'b0, timer0_pkg::ADDR_FLAGS, d);
      check("write_zero_keeps", d, 8'h04);
      @(posedge i_clk);
      #5 i_vector_ack = '{cmp_b: 1'b1, cmp_a: 1'b0, wrap: 1'b0};
      @(posedge i_clk);
      #5 i_vector_ack = '0;
      reg_read(1'b0, timer0_pkg::ADDR_FLAGS, d);
      check("vector_clear_b", d, 8'h00);
      reg_write(1'b0, timer0_pkg::ADDR_COUNT, 8'hFA);
      run_cycles(3'h1, 10);
      reg_read(1'b0, timer0_pkg::ADDR_FLAGS, d);
      check("wrap_flag", d, 8'h01);
      check("wrap_irq_on", {7'h00, o_wrap_irq}, 8'h01);
      reg_write(1'b0, timer0_pkg::ADDR_IRQ_MASK, 8'h06);
      repeat (2) @(posedge i_clk);
      #5 check("wrap_irq_masked", {7'h00, o_wrap_irq}, 8'h00);
      reg_write(1'b0, timer0_pkg::ADDR_IRQ_MASK, 8'h07);
      i_global_irq_enable = 1'b0;
      repeat (2) @(posedge i_clk);
      #5 check("wrap_irq_no_gie", {7'h00, o_wrap_irq}, 8'h00);
      i_vector_ack = '{cmp_b: 1'b0, cmp_a: 1'b0, wrap: 1'b1};
      @(posedge i_clk);
      #5 i_vector_ack = '0;
      reg_read(1'b0, timer0_pkg::ADDR_FLAGS, d);
      check("vector_clear_wrap", d, 8'h00);
   endtask

   task automatic test_write_block;
      reg_write(1'b0, timer0_pkg::ADDR_COUNT, 8'h20);
      run_cycles(3'h1, 8);
      reg_read(1'b0, timer0_pkg::ADDR_FLAGS, d);
      check("blocked_match", d, 8'h04);
      reg_write(1'b0, timer0_pkg::ADDR_FLAGS, 8'h07);
   endtask

   // top = compare A = 3: ctc never wraps, fast wraps at top, phase correct at bottom
   task automatic test_wave_modes;
      logic [2:0] modes [3] = '{3'h2, 3'h7, 3'h5};
      logic [7:0] want [3] = '{8'h02, 8'h03, 8'h03};
      reg_write(1'b0, timer0_pkg::ADDR_CMP_A, 8'h03);
      for (int k = 0; k < 3; k++) begin
         reg_write(1'b0, timer0_pkg::ADDR_FLAGS, 8'h07);
         reg_write(1'b0, timer0_pkg::ADDR_COUNT, 8'h01);
         i_waveform_mode_select = modes[k];
         run_cycles(3'h1, 8);
         reg_read(1'b0, timer0_pkg::ADDR_FLAGS, d);
         check("mode_flags", d, want[k]);
      end
      i_waveform_mode_select = 3'h0;
   endtask

   task automatic test_sync_capture;
      logic [7:0] c0;
      psr_cycles = 0;
      reg_write(1'b0, timer0_pkg::ADDR_SYNC_CTRL, 8'h01);
      reg_read(1'b0, timer0_pkg::ADDR_SYNC_CTRL, d);
      check("psr_self_clear", d, 8'h00);
      check("psr_pulse_cycles", 8'(psr_cycles), 8'h01);
      reg_write(1'b1, 8'h23, 8'h81);
      i_clock_source_select = 3'h2;
      reg_read(1'b0, timer0_pkg::ADDR_COUNT, c0);
      repeat (40) @(posedge i_clk);
      reg_read(1'b0, timer0_pkg::ADDR_COUNT, d);
      check("held_count", d - c0, 8'h00);
      reg_read(1'b0, timer0_pkg::ADDR_SYNC_CTRL, d);
      check("psr_kept", d, 8'h81);
      reg_write(1'b0, timer0_pkg::ADDR_SYNC_CTRL, 8'h00);
      reg_read(1'b0, timer0_pkg::ADDR_SYNC_CTRL, d);
      check("psr_released", d, 8'h00);
      check("psr_line_low", {7'h00, o_prescaler_reset}, 8'h00);
      i_clock_source_select = 3'h0;
      for (int s = 0; s < 2; s++) begin
         reg_write(1'b0, timer0_pkg::ADDR_SYNC_CTRL, s ? 8'h40 : 8'h00);
         i_capture_input_first = ~s[0];
         i_capture_input_second = s[0];
         repeat (2) @(posedge i_clk);
         #5 check("capture_route", {7'h00, o_capture_trigger}, 8'h01);
         i_capture_input_first = s[0];
         i_capture_input_second = ~s[0];
         repeat (2) @(posedge i_clk);
         #5 check("capture_route", {7'h00, o_capture_trigger}, 8'h00);
      end
   endtask

   initial begin
      i_rst_b = 1'b0;
      i_req = '0;
      i_vector_ack = '0;
      i_global_irq_enable = 1'b0;
      i_clock_source_select = 3'h0;
      i_waveform_mode_select = 3'h0;
      i_ext_count_pin = 1'b0;
      i_capture_input_first = 1'b0;
      i_capture_input_second = 1'b0;
      repeat (16) @(posedge i_clk);
      #5 i_rst_b = 1'b1;
      test_reset_values();
      test_register_access();
      test_clock_select();
      test_ext_pin();
      test_flags_irq();
      test_write_block();
      test_wave_modes();
      test_sync_capture();
      give_verdict();
   end
endmodule
`default_nettype wire

// [timer0_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module timer0_ctrl (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire timer0_pkg::reg_req_t i_req,
   input wire timer0_pkg::vector_ack_t i_vector_ack,
   input wire logic i_global_irq_enable,
   input wire logic [2:0] i_clock_source_select,
   input wire logic [2:0] i_waveform_mode_select,
   input wire logic i_ext_count_pin,
   input wire logic i_capture_input_first,
   input wire logic i_capture_input_second,
   output logic [7:0] o_rdata,
   output logic o_wrap_irq,
   output logic o_cmp_a_irq,
   output logic o_cmp_b_irq,
   output logic o_cmp_a_match,
   output logic o_cmp_b_match,
   output logic o_prescaler_reset,
   output logic o_capture_trigger
);
   // data-space offset of an access, or 8'hFF (unmapped) outside the io window
   function automatic logic [7:0] data_offset(input timer0_pkg::reg_req_t r);
      logic [7:0] off;
      off = r.addr;
      if (r.io_space) begin
         if (r.addr <= timer0_pkg::IO_WINDOW_LAST) begin
            off = r.addr + timer0_pkg::IO_ALIAS_OFFSET;
         end else begin
            off = 8'hFF;
         end
      end
      return off;
   endfunction

   // prescaler tap reached: low bits of the shared count all ones
   function automatic logic tap_hit(input logic [timer0_pkg::PRESCALE_WIDTH-1:0] cnt, input int bits);
      logic hit;
      hit = 1'b1;
      for (int i = 0; i < timer0_pkg::PRESCALE_WIDTH; i++) begin
         if (i < bits && !cnt[i]) begin
            hit = 1'b0;
         end
      end
      return hit;
   endfunction

   logic [7:0] offset;
   logic wr_flags, wr_sync, wr_count, wr_cmp_a, wr_cmp_b, wr_mask;
   always_comb begin
      offset = data_offset(i_req);
      wr_flags = i_req.wr && offset == timer0_pkg::ADDR_FLAGS;
      wr_sync = i_req.wr && offset == timer0_pkg::ADDR_SYNC_CTRL;
      wr_count = i_req.wr && offset == timer0_pkg::ADDR_COUNT;
      wr_cmp_a = i_req.wr && offset == timer0_pkg::ADDR_CMP_A;
      wr_cmp_b = i_req.wr && offset == timer0_pkg::ADDR_CMP_B;
      // the mask sits above the io window and has no io alias
      wr_mask = i_req.wr && !i_req.io_space && i_req.addr == timer0_pkg::ADDR_IRQ_MASK;
   end

   // general sync control
   logic sync_hold_reg, sync_hold_next;
   logic capture_sel_reg, capture_sel_next;
   logic psr_reg, psr_next;
   always_comb begin
      sync_hold_next = sync_hold_reg;
      capture_sel_next = capture_sel_reg;
      psr_next = psr_reg;
      if (wr_sync) begin
         sync_hold_next = i_req.wdata[timer0_pkg::BIT_SYNC_HOLD];
         capture_sel_next = i_req.wdata[timer0_pkg::BIT_CAPTURE_SEL];
         psr_next = i_req.wdata[timer0_pkg::BIT_PRESCALER_RESET];
      end else if (!sync_hold_reg) begin
         psr_next = 1'b0;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_hold_reg <= 1'b0;
         capture_sel_reg <= 1'b0;
         psr_reg <= 1'b0;
      end else begin
         sync_hold_reg <= sync_hold_next;
         capture_sel_reg <= capture_sel_next;
         psr_reg <= psr_next;
      end
   end

   // shared prescaler and clock select
   logic [timer0_pkg::PRESCALE_WIDTH-1:0] pre_reg, pre_next;
   logic pin_reg, pin_next;
   logic tick;
   timer0_pkg::clock_source_t cs;
   always_comb begin
      cs = timer0_pkg::clock_source_t'(i_clock_source_select);
      pre_next = psr_reg ? timer0_pkg::PRESCALE_RESET : pre_reg + 10'h001;
      pin_next = i_ext_count_pin;
      tick = 1'b0;
      unique case (cs)
         timer0_pkg::CS_STOP: tick = 1'b0;
         timer0_pkg::CS_DIV1: tick = 1'b1;
         timer0_pkg::CS_DIV8: tick = !psr_reg && tap_hit(pre_reg, 3);
         timer0_pkg::CS_DIV64: tick = !psr_reg && tap_hit(pre_reg, 6);
         timer0_pkg::CS_DIV256: tick = !psr_reg && tap_hit(pre_reg, 8);
         timer0_pkg::CS_DIV1024: tick = !psr_reg && tap_hit(pre_reg, 10);
         // pin level is read regardless of its port direction
         timer0_pkg::CS_EXT_FALL: tick = pin_reg && !i_ext_count_pin;
         timer0_pkg::CS_EXT_RISE: tick = !pin_reg && i_ext_count_pin;
      endcase
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pre_reg <= timer0_pkg::PRESCALE_RESET;
         pin_reg <= 1'b0;
      end else begin
         pre_reg <= pre_next;
         pin_reg <= pin_next;
      end
   end

   // counter, compare values and match blocking
   logic [7:0] count_reg, count_next;
   logic [7:0] cmp_a_reg, cmp_a_next;
   logic [7:0] cmp_b_reg, cmp_b_next;
   logic down_reg, down_next;
   logic block_reg, block_next;
   logic [7:0] top;
   logic phase_correct, wrap_evt, match_a, match_b;
   timer0_pkg::waveform_mode_t wm;
   always_comb begin
      wm = timer0_pkg::waveform_mode_t'(i_waveform_mode_select);
      phase_correct = wm == timer0_pkg::WM_PC_FF || wm == timer0_pkg::WM_PC_OCRA;
      top = (wm == timer0_pkg::WM_CTC || wm == timer0_pkg::WM_PC_OCRA || wm == timer0_pkg::WM_FAST_OCRA)
         ? cmp_a_reg : timer0_pkg::COUNT_MAX;
      count_next = count_reg;
      down_next = down_reg;
      wrap_evt = 1'b0;
      if (tick) begin
         if (phase_correct) begin
            if (down_reg) begin
               if (count_reg == timer0_pkg::COUNT_BOTTOM) begin
                  down_next = 1'b0;
                  count_next = count_reg + 8'h01;
                  wrap_evt = 1'b1;
               end else begin
                  count_next = count_reg - 8'h01;
               end
            end else if (count_reg >= top) begin
               down_next = 1'b1;
               count_next = count_reg - 8'h01;
            end else begin
               count_next = count_reg + 8'h01;
            end
         end else if (count_reg == top) begin
            count_next = timer0_pkg::COUNT_BOTTOM;
            // overflow at max, except fast pwm with a programmed top
            wrap_evt = (wm == timer0_pkg::WM_FAST_OCRA) || (count_reg == timer0_pkg::COUNT_MAX);
         end else begin
            count_next = count_reg + 8'h01;
            wrap_evt = count_reg == timer0_pkg::COUNT_MAX;
         end
      end
      match_a = tick && !block_reg && count_reg == cmp_a_reg;
      match_b = tick && !block_reg && count_reg == cmp_b_reg;
      block_next = block_reg;
      if (wr_count) begin
         count_next = i_req.wdata;
         block_next = 1'b1;
      end else if (tick) begin
         block_next = 1'b0;
      end
      cmp_a_next = wr_cmp_a ? i_req.wdata : cmp_a_reg;
      cmp_b_next = wr_cmp_b ? i_req.wdata : cmp_b_reg;
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         count_reg <= timer0_pkg::RESET_BYTE;
         cmp_a_reg <= timer0_pkg::RESET_BYTE;
         cmp_b_reg <= timer0_pkg::RESET_BYTE;
         down_reg <= 1'b0;
         block_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         cmp_a_reg <= cmp_a_next;
         cmp_b_reg <= cmp_b_next;
         down_reg <= down_next;
         block_reg <= block_next;
      end
   end

   // flags, mask and requests
   logic [2:0] flags_reg, flags_next;
   logic [2:0] mask_reg, mask_next;
   logic [2:0] set_evt, clr_evt;
   always_comb begin
      set_evt = {match_b, match_a, wrap_evt};
      clr_evt = {i_vector_ack.cmp_b, i_vector_ack.cmp_a, i_vector_ack.wrap};
      if (wr_flags) begin
         clr_evt = clr_evt | i_req.wdata[2:0];
      end
      flags_next = set_evt | (flags_reg & ~clr_evt);
      mask_next = wr_mask ? i_req.wdata[2:0] : mask_reg;
   end

   logic [7:0] rdata_next;
   always_comb begin
      rdata_next = timer0_pkg::RESET_BYTE;
      if (i_req.rd) begin
         if (!i_req.io_space && i_req.addr == timer0_pkg::ADDR_IRQ_MASK) begin
            rdata_next = {5'h00, mask_reg};
         end else begin
            unique case (offset)
               timer0_pkg::ADDR_FLAGS: rdata_next = {5'h00, flags_reg};
               timer0_pkg::ADDR_SYNC_CTRL: rdata_next = {sync_hold_reg, capture_sel_reg, 5'h00, psr_reg};
               timer0_pkg::ADDR_COUNT: rdata_next = count_reg;
               timer0_pkg::ADDR_CMP_A: rdata_next = cmp_a_reg;
               timer0_pkg::ADDR_CMP_B: rdata_next = cmp_b_reg;
               default: rdata_next = timer0_pkg::RESET_BYTE;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flags_reg <= 3'h0;
         mask_reg <= 3'h0;
         o_rdata <= timer0_pkg::RESET_BYTE;
         o_wrap_irq <= 1'b0;
         o_cmp_a_irq <= 1'b0;
         o_cmp_b_irq <= 1'b0;
         o_cmp_a_match <= 1'b0;
         o_cmp_b_match <= 1'b0;
         o_prescaler_reset <= 1'b0;
         o_capture_trigger <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         mask_reg <= mask_next;
         o_rdata <= rdata_next;
         o_wrap_irq <= flags_next[timer0_pkg::BIT_WRAP] && mask_next[timer0_pkg::BIT_WRAP] && i_global_irq_enable;
         o_cmp_a_irq <= flags_next[timer0_pkg::BIT_CMP_A] && mask_next[timer0_pkg::BIT_CMP_A] && i_global_irq_enable;
         o_cmp_b_irq <= flags_next[timer0_pkg::BIT_CMP_B] && mask_next[timer0_pkg::BIT_CMP_B] && i_global_irq_enable;
         o_cmp_a_match <= match_a;
         o_cmp_b_match <= match_b;
         o_prescaler_reset <= psr_next;
         o_capture_trigger <= capture_sel_next ? i_capture_input_second : i_capture_input_first;
      end
   end

   // checks
   sequence s_count_write;
      wr_count;
   endsequence
   sequence s_tick_blocked;
      !wr_count [*1] ##0 tick;
   endsequence

   property p_psr_self_clear;
      @(posedge i_clk) disable iff (!i_rst_b) (psr_reg && !sync_hold_reg && !wr_sync) |=> !psr_reg;
   endproperty
   a_psr_self_clear: assert property (p_psr_self_clear) else $error("prescaler reset did not self-clear");

   property p_psr_held;
      @(posedge i_clk) disable iff (!i_rst_b) (psr_reg && sync_hold_reg && !wr_sync) |=> psr_reg;
   endproperty
   a_psr_held: assert property (p_psr_held) else $error("prescaler reset lost in sync hold");

   property p_prescaler_halts;
      @(posedge i_clk) disable iff (!i_rst_b) psr_reg |=> pre_reg == timer0_pkg::PRESCALE_RESET;
   endproperty
   a_prescaler_halts: assert property (p_prescaler_halts) else $error("prescaler ran during reset");

   property p_stop_holds;
      @(posedge i_clk) disable iff (!i_rst_b)
         (cs == timer0_pkg::CS_STOP && !wr_count) |=> count_reg == $past(count_reg);
   endproperty
   a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped");

   property p_div8_tap;
      @(posedge i_clk) disable iff (!i_rst_b)
         (cs == timer0_pkg::CS_DIV8 && tick) |-> pre_reg[2:0] == 3'h7 && !psr_reg;
   endproperty
   a_div8_tap: assert property (p_div8_tap) else $error("div8 tick off its tap");

   property p_rise_edge;
      @(posedge i_clk) disable iff (!i_rst_b)
         (cs == timer0_pkg::CS_EXT_RISE && $rose(i_ext_count_pin)) |-> tick;
   endproperty
   a_rise_edge: assert property (p_rise_edge) else $error("rising pin edge not counted");

   property p_write_blocks_match;
      @(posedge i_clk) disable iff (!i_rst_b) s_count_write ##1 s_tick_blocked |-> !match_a && !match_b;
   endproperty
   a_write_blocks_match: assert property (p_write_blocks_match) else $error("match not blocked after write");

   property p_set_wins;
      @(posedge i_clk) disable iff (!i_rst_b) (match_a && wr_flags && i_req.wdata[1]) |=> flags_reg[1];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat compare A set");

   property p_w1c;
      @(posedge i_clk) disable iff (!i_rst_b)
         (wr_flags && i_req.wdata[0] && !wrap_evt) |=> !flags_reg[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("wrap flag not cleared by write one");

   property p_irq_gate;
      @(posedge i_clk) disable iff (!i_rst_b)
         o_cmp_b_irq |-> flags_reg[2] && mask_reg[2] && $past(i_global_irq_enable);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("compare B request without its causes");

   property p_count_load;
      @(posedge i_clk) disable iff (!i_rst_b) wr_count |=> count_reg == $past(i_req.wdata);
   endproperty
   a_count_load: assert property (p_count_load) else $error("count write not loaded");
endmodule
`default_nettype wire

// [timer0_pkg.sv]
// Behaviour
// - select codes 010..101 take prescaler taps clk/8, /64, /256, /1024
// - code 110 counts falling edges of count pin, 111 rising edges
// - count pin edges clock the counter even when the pin is an output
// - overflow request only with wrap enable bit 0, global enable and flag
// - compare A request only with enable bit 1, global enable and flag
// - compare B request only with enable bit 2, global enable and flag
// - with sync hold bit 7 set, prescaler reset bit keeps its written value
// - writing sync hold to zero makes hardware clear prescaler reset bit
// - prescaler reset bit 0 resets shared prescaler, self-clears unless sync hold
// - capture select bit 6 routes first input when zero, second when one
// - count value register reads and loads the 8-bit counter directly
// - a count value write blocks the compare match on the next timer clock
// - compare A value compared continuously, match drives flag and wave pin
// - compare B value compared continuously, match drives flag and wave pin
// - compare B flag bit 2 sets on match, clears on vector or write one
// - compare A flag bit 1 sets on match, clears on vector or write one
// - wrap flag bit 0 sets on overflow, clears on vector or write one
// - overflow point depends on selected waveform mode
// - aliased registers also decode at offset minus 0x20 in I/O window 0x00-0x3F
// - code 000 stops counter, code 001 counts every I/O clock
package timer0_pkg;
   localparam logic [7:0] ADDR_FLAGS = 8'h35;
   localparam logic [7:0] ADDR_SYNC_CTRL = 8'h43;
   localparam logic [7:0] ADDR_COUNT = 8'h46;
   localparam logic [7:0] ADDR_CMP_A = 8'h47;
   localparam logic [7:0] ADDR_CMP_B = 8'h48;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h6E;
   localparam logic [7:0] IO_ALIAS_OFFSET = 8'h20;
   localparam logic [7:0] IO_WINDOW_LAST = 8'h3F;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam int BIT_WRAP = 0;
   localparam int BIT_CMP_A = 1;
   localparam int BIT_CMP_B = 2;
   localparam int BIT_SYNC_HOLD = 7;
   localparam int BIT_CAPTURE_SEL = 6;
   localparam int BIT_PRESCALER_RESET = 0;
   localparam int PRESCALE_WIDTH = 10;
   localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_RESET = 10'h000;

   typedef enum logic [2:0] {
      CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
      CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
   } clock_source_t;

   typedef enum logic [2:0] {
      WM_NORMAL = 3'h0, WM_PC_FF = 3'h1, WM_CTC = 3'h2, WM_FAST_FF = 3'h3,
      WM_RES4 = 3'h4, WM_PC_OCRA = 3'h5, WM_RES6 = 3'h6, WM_FAST_OCRA = 3'h7
   } waveform_mode_t;

   // one cpu register access per cycle; io_space marks IN/OUT addressing
   typedef struct packed {
      logic wr;
      logic rd;
      logic io_space;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // hardware clear of a flag when its vector executes
   typedef struct packed {
      logic cmp_b;
      logic cmp_a;
      logic wrap;
   } vector_ack_t;
endpackage
